// *** core/fsc_switch_ctrl.sv ***
// Four-path switch control and status register behind an APB slave
`timescale 1ns/1ps
// How it works
// RQ1: Control register at 0x20, all bits reset to zero, paths open.
// RQ2: Bits 7:6 report read-only fault code; 00 means no fault.
// RQ3: Software writes zeros to bits 5:4; they are reserved, read zero.
// RQ4: Bit 3 closes or opens path to port one A.
// RQ5: Bit 2 closes or opens path to port two A.
// RQ6: Bit 1 closes or opens path to port two B.
// RQ7: Bit 0 closes or opens path to port one B.
// RQ8: A configuration error at power-up raises a nonzero fault code.
// RQ9: Read returns switch bits, current fault code, reserved bits zero.
module fsc_switch_ctrl
    import fsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] cfg_status,
    output logic port_one_a,
    output logic port_two_a,
    output logic port_two_b,
    output logic port_one_b,
    output logic irq
);
    fsc_cfg_if cfg();
    logic [3:0] path_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic [1:0] irq_set;
    logic access, wr_en, rd_en, lane0;
    logic path_wr;
    logic done_prev_reg;

    fsc_cfg_check i_fsc_cfg_check (
        .pclk(pclk),
        .presetn(presetn),
        .cfg_status(cfg_status),
        .cfg(cfg)
    );

    // Known offsets only; anything else answers with an error
    function automatic logic addr_ok(input logic [7:0] a);
        return a == FSC_SWITCH_CTRL_OFFS || a == FSC_IRQ_STATUS_OFFS ||
               a == FSC_IRQ_MASK_OFFS || a == FSC_CONFIG_OFFS;
    endfunction

    // One wait state: pready is registered, so the access phase takes two
    // cycles; writes land only at the completing edge, as the bus expects
    assign access = psel && penable && !pready;
    assign wr_en = psel && penable && pready && pwrite && addr_ok(paddr);
    assign rd_en = access && !pwrite;
    assign lane0 = pstrb[0];
    assign path_wr = wr_en && lane0 && paddr == FSC_SWITCH_CTRL_OFFS;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= access;
            pslverr <= access && !addr_ok(paddr);
        end
    end

    // RQ1: reset all paths open
    // RQ3: bits 5:4 are not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            path_reg <= FSC_SWITCH_CTRL_RESET[3:0];
        end else if (path_wr) begin
            path_reg <= pwdata[3:0];
        end
    end

    // Switch drive pins follow the register one cycle later
    // RQ4: path one A
    // RQ5: path two A
    // RQ6: path two B
    // RQ7: path one B
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_one_a <= 1'b0;
            port_two_a <= 1'b0;
            port_two_b <= 1'b0;
            port_one_b <= 1'b0;
        end else begin
            port_one_a <= path_reg[FSC_PATH_ONE_BIT];
            port_two_a <= path_reg[FSC_PATH_TWO_BIT];
            port_two_b <= path_reg[FSC_PATH_THREE_BIT];
            port_one_b <= path_reg[FSC_PATH_FOUR_BIT];
        end
    end

    // Previous done level, so the fault event fires once on its rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_prev_reg <= 1'b0;
        end else begin
            done_prev_reg <= cfg.done;
        end
    end

    // Events: a nonzero fault latched, or the switch pattern changed
    always_comb begin
        irq_set = 2'h0;
        irq_set[FSC_IRQ_FAULT_BIT] = cfg.done && !done_prev_reg &&
            cfg.fault_code != FSC_FAULT_NONE;
        irq_set[FSC_IRQ_CHANGE_BIT] = path_wr && pwdata[3:0] != path_reg;
    end

    // Write-one-to-clear; a new event in the same cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= 2'h0;
        end else if (wr_en && lane0 && paddr == FSC_IRQ_STATUS_OFFS) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[1:0]) | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= FSC_IRQ_MASK_RESET;
        end else if (wr_en && lane0 && paddr == FSC_IRQ_MASK_OFFS) begin
            irq_mask_reg <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Read data: registered, only while a read completes
    // RQ2: fault code read-only
    // RQ9: read back composition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                FSC_SWITCH_CTRL_OFFS:
                    prdata <= {24'h00_0000, cfg.fault_code, 2'h0, path_reg};
                FSC_IRQ_STATUS_OFFS: prdata <= {30'h0, irq_stat_reg};
                FSC_IRQ_MASK_OFFS: prdata <= {30'h0, irq_mask_reg};
                FSC_CONFIG_OFFS: prdata <= {31'h0, cfg.done};
                default: prdata <= 32'h0000_0000;
            endcase
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    sequence s_ctrl_write;
        psel && penable && pwrite && pready && pstrb[0] &&
            paddr == FSC_SWITCH_CTRL_OFFS;
    endsequence

    // RQ1: open after reset
    a_reset_open: assert property (@(posedge pclk)
        $rose(presetn) |-> path_reg == 4'h0 && !port_one_a)
        else $error("paths not open after reset");
    // RQ4: port one A follows write
    a_path_one: assert property (@(posedge pclk) disable iff (!presetn)
        s_ctrl_write |-> ##2 port_one_a == $past(pwdata[3], 2))
        else $error("port one A does not follow bit 3");
    // RQ5: port two A follows write
    a_path_two: assert property (@(posedge pclk) disable iff (!presetn)
        s_ctrl_write |-> ##2 port_two_a == $past(pwdata[2], 2))
        else $error("port two A does not follow bit 2");
    // RQ6: port two B follows write
    a_path_three: assert property (@(posedge pclk) disable iff (!presetn)
        s_ctrl_write |-> ##2 port_two_b == $past(pwdata[1], 2))
        else $error("port two B does not follow bit 1");
    // RQ7: port one B follows write
    a_path_four: assert property (@(posedge pclk) disable iff (!presetn)
        s_ctrl_write |-> ##2 port_one_b == $past(pwdata[0], 2))
        else $error("port one B does not follow bit 0");
    // RQ3: reserved bits read zero
    a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && paddr == FSC_SWITCH_CTRL_OFFS |=> prdata[5:4] == 2'h0)
        else $error("reserved bits not zero");
    // RQ2: fault field read back
    a_fault_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && paddr == FSC_SWITCH_CTRL_OFFS |=>
            prdata[7:6] == $past(cfg.fault_code) && pready)
        else $error("fault field wrong on read");
    // RQ9: switch bits read back
    a_switch_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && paddr == FSC_SWITCH_CTRL_OFFS |=>
            prdata[3:0] == $past(path_reg))
        else $error("switch bits wrong on read");

    // Answer lasts one cycle so a held request is not taken twice
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready held longer than one cycle");
    // Unmapped offsets answer with an error
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        access && !addr_ok(paddr) |=> pready && pslverr)
        else $error("unmapped access without error");
    // RQ8: nonzero fault raises status
    a_fault_event: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.done && !done_prev_reg && cfg.fault_code != FSC_FAULT_NONE |=>
            irq_stat_reg[FSC_IRQ_FAULT_BIT])
        else $error("fault event not recorded");
    // Clear without a new event empties the fault bit
    a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && lane0 && paddr == FSC_IRQ_STATUS_OFFS &&
            pwdata[FSC_IRQ_FAULT_BIT] && !irq_set[FSC_IRQ_FAULT_BIT] |=>
            !irq_stat_reg[FSC_IRQ_FAULT_BIT])
        else $error("fault status not cleared");
    // Unmasked pending status drives the interrupt line
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        |(irq_stat_reg & irq_mask_reg) |=> irq)
        else $error("interrupt not raised for pending status");
endmodule

// *** core/fsc_pkg.sv ***
// Package: register map, field layout and timing for the switch control block
package fsc_pkg;
    localparam logic [7:0] FSC_SWITCH_CTRL_OFFS = 8'h20;
    localparam logic [7:0] FSC_IRQ_STATUS_OFFS = 8'h24;
    localparam logic [7:0] FSC_IRQ_MASK_OFFS = 8'h28;
    localparam logic [7:0] FSC_CONFIG_OFFS = 8'h2c;
    localparam logic [7:0] FSC_SWITCH_CTRL_RESET = 8'h00;
    localparam int FSC_FAULT_MSB = 7;
    localparam int FSC_FAULT_LSB = 6;
    localparam int FSC_RSVD_MSB = 5;
    localparam int FSC_RSVD_LSB = 4;
    localparam int FSC_PATH_ONE_BIT = 3;
    localparam int FSC_PATH_TWO_BIT = 2;
    localparam int FSC_PATH_THREE_BIT = 1;
    localparam int FSC_PATH_FOUR_BIT = 0;
    localparam logic [1:0] FSC_FAULT_NONE = 2'h0;
    // Interrupt status bits: fault seen, switch pattern changed
    localparam int FSC_IRQ_FAULT_BIT = 0;
    localparam int FSC_IRQ_CHANGE_BIT = 1;
    localparam logic [1:0] FSC_IRQ_MASK_RESET = 2'h0;
    // Power-up configuration check window
    localparam int FSC_CHECK_TIME_NS = 1000;
    localparam int FSC_CLK_PERIOD_NS = 40;
    localparam int FSC_CHECK_CYCLES =
        (FSC_CHECK_TIME_NS + FSC_CLK_PERIOD_NS - 1) / FSC_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        FSC_ST_CHECK = 2'b00,
        FSC_ST_EVAL = 2'b01,
        FSC_ST_RUN = 2'b11
    } fsc_state_t;
endpackage

// *** core/fsc_cfg_if.sv ***
// Interface: power-up configuration result from checker to register file
`timescale 1ns/1ps
interface fsc_cfg_if;
    logic [1:0] fault_code;
    logic done;
    modport chk (output fault_code, output done);
    modport regfile (input fault_code, input done);
endinterface

// *** core/fsc_cfg_check.sv ***
// Power-up configuration checker: waits, then samples the config status
`timescale 1ns/1ps
module fsc_cfg_check
    import fsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] cfg_status,
    fsc_cfg_if.chk cfg
);
    logic [1:0] s1_reg, s2_reg, s3_reg;
    logic [1:0] stable_reg;
    logic [$clog2(FSC_CHECK_CYCLES+1)-1:0] cnt_reg;
    fsc_state_t state_reg;

    // Three-stage synchroniser; a value counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 2'h0;
            s2_reg <= 2'h0;
            s3_reg <= 2'h0;
        end else begin
            s1_reg <= cfg_status;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_reg <= 2'h0;
        end else if (s2_reg == s3_reg) begin
            stable_reg <= s3_reg;
        end
    end

    // Sequencer: let the status settle, then latch it once
    // RQ8: latch fault code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= FSC_ST_CHECK;
            cnt_reg <= '0;
            cfg.fault_code <= FSC_FAULT_NONE;
            cfg.done <= 1'b0;
        end else begin
            case (state_reg)
                FSC_ST_CHECK: begin
                    if (cnt_reg ==
                            ($bits(cnt_reg))'(FSC_CHECK_CYCLES - 1)) begin
                        state_reg <= FSC_ST_EVAL;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                FSC_ST_EVAL: begin
                    cfg.fault_code <= stable_reg;
                    cfg.done <= 1'b1;
                    state_reg <= FSC_ST_RUN;
                end
                FSC_ST_RUN: begin
                    state_reg <= FSC_ST_RUN;
                end
                default: begin
                    state_reg <= FSC_ST_CHECK;
                end
            endcase
        end
    end

    // RQ8: code held after check
    a_fault_held: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == FSC_ST_RUN |=> $stable(cfg.fault_code))
        else $error("fault code changed after power-up check");
endmodule

// *** bench/fsc_switch_ctrl_test.sv ***
// Self-checking bench for the switch control register block
`timescale 1ns/1ps
`define CHECK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module fsc_switch_ctrl_test;
    import fsc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    wire logic [3:0] ports;
    logic [1:0] cfg_status;
    logic er;
    int err_total, cmp_count, cycles;
    fsc_switch_ctrl i_fsc_switch_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg_status(cfg_status),
        .port_one_a(ports[3]), .port_two_a(ports[2]),
        .port_two_b(ports[1]), .port_one_b(ports[0]), .irq(irq));
    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Hang guard, far above the few hundred cycles the tests need
    initial begin
        cycles = 0;
        forever begin
            @(posedge pclk);
            cycles++;
            if (cycles > 20000) begin
                err_total++;
                tally_and_finish();
            end
        end
    end
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One APB transfer; waits for pready with a bounded count
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) err_total++;
        // Let registered outputs such as ports and irq settle
        repeat (2) @(posedge pclk);
    endtask
    // Reset with a given config pin level, then wait out the check window
    task automatic do_reset(input logic [1:0] cfg);
        cfg_status <= cfg;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (FSC_CHECK_CYCLES + 15) @(posedge pclk);
        apb(1'b0, FSC_CONFIG_OFFS, 32'h0, 4'h0);
        `CHECK(rd[0], 1'b1)
    endtask
    task automatic t_reset_values();
        `CHECK(ports, 4'h0)
        apb(1'b0, FSC_SWITCH_CTRL_OFFS, 32'h0, 4'h0);
        `CHECK(rd, 32'h0)
        apb(1'b0, FSC_IRQ_MASK_OFFS, 32'h0, 4'h0);
        `CHECK(rd[1:0], FSC_IRQ_MASK_RESET)
        `CHECK(irq, 1'b0)
        $display("Test reset values done");
    endtask
    // Each switch bit alone, then back to open
    task automatic t_switch_bits();
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, FSC_SWITCH_CTRL_OFFS, 32'h1 << i, 4'h1);
            `CHECK(ports, 4'h1 << i)
            apb(1'b0, FSC_SWITCH_CTRL_OFFS, 32'h0, 4'h0);
            `CHECK(rd, 32'h1 << i)
        end
        apb(1'b1, FSC_SWITCH_CTRL_OFFS, 32'h0, 4'h1);
        `CHECK(ports, 4'h0)
        $display("Test switch bits done");
    endtask
    // Ones into the fault and reserved fields must not stick
    task automatic t_reserved();
        apb(1'b1, FSC_SWITCH_CTRL_OFFS, 32'hffff_ffff, 4'hf);
        apb(1'b0, FSC_SWITCH_CTRL_OFFS, 32'h0, 4'h0);
        `CHECK(rd, 32'h0000_000f)
        `CHECK(rd[7:6], FSC_FAULT_NONE)
        `CHECK(ports, 4'hf)
        $display("Test reserved bits done");
    endtask
    // Unmapped address and a write with the low strobe off
    task automatic t_refusals();
        apb(1'b1, 8'h40, 32'h0, 4'h1);
        `CHECK(er, 1'b1)
        apb(1'b0, 8'h40, 32'h0, 4'h0);
        `CHECK(er, 1'b1)
        `CHECK(rd, 32'h0)
        apb(1'b1, FSC_SWITCH_CTRL_OFFS, 32'h0, 4'he);
        apb(1'b0, FSC_SWITCH_CTRL_OFFS, 32'h0, 4'h0);
        `CHECK(er, 1'b0)
        `CHECK(rd, 32'h0000_000f)
        $display("Test refusals done");
    endtask
    // Power-up config error reported, then routed to the interrupt
    task automatic t_fault();
        do_reset(2'h2);
        apb(1'b0, FSC_SWITCH_CTRL_OFFS, 32'h0, 4'h0);
        `CHECK(rd, 32'h0000_0080)
        apb(1'b1, FSC_SWITCH_CTRL_OFFS, 32'h5, 4'h1);
        apb(1'b0, FSC_SWITCH_CTRL_OFFS, 32'h0, 4'h0);
        `CHECK(rd, 32'h0000_0085)
        apb(1'b0, FSC_IRQ_STATUS_OFFS, 32'h0, 4'h0);
        `CHECK(rd[1:0], 2'h3)
        `CHECK(irq, 1'b0)
        apb(1'b1, FSC_IRQ_MASK_OFFS, 32'h1, 4'h1);
        `CHECK(irq, 1'b1)
        apb(1'b1, FSC_IRQ_STATUS_OFFS, 32'h3, 4'h1);
        `CHECK(irq, 1'b0)
        apb(1'b0, FSC_IRQ_STATUS_OFFS, 32'h0, 4'h0);
        `CHECK(rd[1:0], 2'h0)
        $display("Test fault and interrupt done");
    endtask
    initial begin
        err_total = 0;
        cmp_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        cfg_status = 2'h0;
        do_reset(2'h0);
        t_reset_values();
        t_switch_bits();
        t_reserved();
        t_refusals();
        t_fault();
        tally_and_finish();
    end
endmodule
